// *** rtl/spc_regs.sv ***
// Serial configuration port with control, identification and preset profile registers
// ==========================================================
// Functional notes
// - Bit-order 0: MSB first, address decrements
// - Bit-order 1: LSB first, address increments
// - Soft reset reloads selected profile values
// - Hardware reset keeps registers, never self-clears
// - Strength bit reduces pin drive, profile default
// - Read-target selects live or buffered copies
// - Update strobe applies pending values, self-clears
// - Identification registers are read-only
// - Identification code MSB at lowest address
// - Profile read returns last loaded index
// - Profile write selects one of 64
// - Profile write reloads profile-dependent registers
// - Profile index initialised from strap pins
// - Control bits are active high
`timescale 1ns/10ps
`include "spc_defines.svh"

module spc_regs #(
  parameter logic [31:0] ID_CODE = 32'h0000_5a01 // Arbitrary identification value
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire spc_pkg::spc_pins_s pins,
  input wire logic [5:0] strap_pins,
  output logic sdio_out,
  output logic sdio_oe_b,
  output spc_pkg::spc_core_s core,
  output logic [63:0] user_cfg
);
  import spc_pkg::*;

  // ==========================================================
  // Helper functions
  // True when the address falls in the buffered user window
  function automatic logic is_user(input logic [14:0] a);
    is_user = (a >= `SPC_ADR_USER_BASE) && (a <= `SPC_ADR_USER_LAST);
  endfunction : is_user

  // Index into the user window
  function automatic logic [2:0] user_idx(input logic [14:0] a);
    user_idx = a[2:0];
  endfunction : user_idx

  // Shift one serial bit into the receive register in frame order
  function automatic logic [15:0] shift_bit(input logic [15:0] s, input logic b, input logic lsb);
    shift_bit = lsb ? {b, s[15:1]} : {s[14:0], b};
  endfunction : shift_bit

  // ==========================================================
  // Input synchronisers
  spc_pins_s pin_meta; // First stage, read only by the second
  spc_pins_s pin_sync; // Safe copy
  logic sclk_prev; // For edge detection
  logic [5:0] strap_meta; // First stage of strap levels
  logic [5:0] strap_sync; // Safe strap levels
  logic sclk_rise;
  logic sclk_fall;

  // Two flops on every pin before any logic reads it
  always_ff @(posedge clk_sys) begin
    pin_meta <= pins;
    pin_sync <= pin_meta;
    strap_meta <= strap_pins;
    strap_sync <= strap_meta;
    sclk_prev <= rst_b ? pin_sync.sclk : 1'b0;
  end

  assign sclk_rise = pin_sync.sclk & ~sclk_prev;
  assign sclk_fall = ~pin_sync.sclk & sclk_prev;

  // ==========================================================
  // Register state
  logic lsb_first, next_lsb_first; // Bit and byte order for next frame
  logic soft_rst, next_soft_rst; // Reads 1 while a soft-reset profile reload runs
  logic hw_rst, next_hw_rst; // Core reset level
  logic drive_low, next_drive_low; // Reduced pin strength
  logic read_buf, next_read_buf; // Read target
  logic upd, next_upd; // Update strobe
  logic [5:0] profile, next_profile; // Last loaded profile index
  logic strap_done, next_strap_done; // Strap capture taken
  logic [7:0][7:0] user_buf, next_user_buf; // Pending user bytes
  logic [7:0][7:0] user_live, next_user_live; // Applied user bytes
  spc_load_e ld_state, next_ld_state; // Profile loader
  logic [3:0] ld_idx, next_ld_idx; // Loader entry
  spc_core_s next_core;
  logic [7:0] rom_byte;
  logic [7:0] rd_data; // Read mux result

  // Serial engine outputs used by the register group
  logic wr_pulse;
  logic [14:0] wr_addr;
  logic [7:0] wr_data;
  logic [14:0] addr;

  spc_profile_rom u_rom (
    .profile(profile),
    .index(ld_idx),
    .data(rom_byte)
  );

  // ==========================================================
  // Register next state
  always_comb begin
    next_lsb_first = lsb_first;
    next_soft_rst = soft_rst;
    next_hw_rst = hw_rst;
    next_drive_low = drive_low;
    next_read_buf = read_buf;
    next_upd = 1'b0;
    next_profile = profile;
    next_strap_done = strap_done;
    next_user_buf = user_buf;
    next_user_live = user_live;
    next_ld_state = ld_state;
    next_ld_idx = ld_idx;
    if (upd) begin
      next_user_live = user_buf;
    end
    if (!strap_done) begin
      next_profile = strap_sync;
      next_strap_done = 1'b1;
      next_ld_state = spc_ld_run;
      next_ld_idx = 4'h0;
    end else if (wr_pulse) begin
      unique case (wr_addr)
        `SPC_ADR_SER_CFG: begin
          next_lsb_first = wr_data[`SPC_BIT_LSB_FIRST];
          if (wr_data[`SPC_BIT_SOFT_RST]) begin
            next_soft_rst = 1'b1;
            next_lsb_first = 1'b0;
            next_hw_rst = 1'b0;
            next_read_buf = 1'b0;
            next_ld_state = spc_ld_run;
            next_ld_idx = 4'h0;
          end
        end
        `SPC_ADR_PORT_CTL: begin
          next_hw_rst = wr_data[`SPC_BIT_HW_RST];
          next_drive_low = wr_data[`SPC_BIT_DRIVE_LOW];
          next_read_buf = wr_data[`SPC_BIT_READ_BUF];
        end
        `SPC_ADR_UPDATE: begin
          next_upd = wr_data[`SPC_BIT_UPDATE];
        end
        `SPC_ADR_PROFILE: begin
          next_profile = wr_data[5:0];
          next_ld_state = spc_ld_run;
          next_ld_idx = 4'h0;
        end
        default: begin
          // Pending user byte; identification writes drop here
          // Read-only identification
          if (is_user(wr_addr) && ld_state == spc_ld_idle) begin
            next_user_buf[user_idx(wr_addr)] = wr_data;
          end
        end
      endcase
    end
    if (ld_state == spc_ld_run && next_ld_state == spc_ld_run && next_ld_idx == ld_idx) begin
      if (ld_idx == `SPC_LOAD_LAST) begin
        next_drive_low = rom_byte[0];
        next_ld_state = spc_ld_idle;
        next_soft_rst = 1'b0;
      end else begin
        next_user_buf[ld_idx[2:0]] = rom_byte;
        next_user_live[ld_idx[2:0]] = rom_byte;
        next_ld_idx = ld_idx + 4'h1;
      end
    end
    next_core.core_reset = next_hw_rst;
    next_core.drive_reduced = next_drive_low;
    next_core.update_pulse = upd;
    next_core.loading = (next_ld_state == spc_ld_run);
    next_core.profile = next_profile;
  end

  // Register storage
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lsb_first <= 1'b0;
      soft_rst <= 1'b0;
      hw_rst <= 1'b0;
      drive_low <= 1'b0;
      read_buf <= 1'b0;
      upd <= 1'b0;
      profile <= `SPC_RST_PROFILE;
      strap_done <= 1'b0;
      user_buf <= '0;
      user_live <= '0;
      ld_state <= spc_ld_idle;
      ld_idx <= 4'h0;
      core <= '0;
    end else begin
      lsb_first <= next_lsb_first;
      soft_rst <= next_soft_rst;
      hw_rst <= next_hw_rst;
      drive_low <= next_drive_low;
      read_buf <= next_read_buf;
      upd <= next_upd;
      profile <= next_profile;
      strap_done <= next_strap_done;
      user_buf <= next_user_buf;
      user_live <= next_user_live;
      ld_state <= next_ld_state;
      ld_idx <= next_ld_idx;
      core <= next_core;
    end
  end

  assign user_cfg = user_live;

  // ==========================================================
  // Read mux
  always_comb begin
    rd_data = `SPC_RST_BYTE;
    unique case (addr)
      `SPC_ADR_SER_CFG: rd_data[`SPC_BIT_LSB_FIRST] = lsb_first;
      `SPC_ADR_PORT_CTL: begin
        rd_data[`SPC_BIT_HW_RST] = hw_rst;
        rd_data[`SPC_BIT_DRIVE_LOW] = drive_low;
        rd_data[`SPC_BIT_READ_BUF] = read_buf;
      end
      `SPC_ADR_UPDATE: rd_data[`SPC_BIT_UPDATE] = upd;
      `SPC_ADR_ID3: rd_data = ID_CODE[31:24];
      `SPC_ADR_ID2: rd_data = ID_CODE[23:16];
      `SPC_ADR_ID1: rd_data = ID_CODE[15:8];
      `SPC_ADR_ID0: rd_data = ID_CODE[7:0];
      `SPC_ADR_PROFILE: rd_data = {2'b00, profile};
      default: begin
        if (is_user(addr)) begin
          rd_data = read_buf ? user_buf[user_idx(addr)] : user_live[user_idx(addr)];
        end
      end
    endcase
    if (addr == `SPC_ADR_SER_CFG) begin
      rd_data[`SPC_BIT_SOFT_RST] = soft_rst;
    end
  end

  // ==========================================================
  // Serial engine state
  spc_ser_e sp_state, next_sp_state;
  logic [4:0] bit_cnt, next_bit_cnt; // Bits of instruction or byte
  logic [15:0] rx, next_rx; // Receive shifter
  logic frame_lsb, next_frame_lsb; // Order latched at frame start
  logic is_read, next_is_read; // Frame direction
  logic [14:0] next_addr;
  logic load_tx, next_load_tx; // Fetch read byte next cycle
  logic [7:0] tx, next_tx; // Transmit shifter
  logic next_sdio_out;
  logic next_sdio_oe_b;
  logic next_wr_pulse;
  logic [14:0] next_wr_addr;
  logic [7:0] next_wr_data;
  logic [15:0] rx_sh;

  // Frame decoding, address stepping and read shifting
  always_comb begin
    next_sp_state = sp_state;
    next_bit_cnt = bit_cnt;
    next_rx = rx;
    next_frame_lsb = frame_lsb;
    next_is_read = is_read;
    next_addr = addr;
    next_load_tx = 1'b0;
    next_tx = tx;
    next_sdio_out = sdio_out;
    next_wr_pulse = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    rx_sh = shift_bit(rx, pin_sync.sdio_in, frame_lsb);
    if (load_tx) begin
      next_tx = rd_data;
    end
    if (pin_sync.cs_b) begin
      next_sp_state = spc_sp_idle;
    end else begin
      unique case (sp_state)
        spc_sp_idle: begin
          next_frame_lsb = lsb_first;
          next_bit_cnt = 5'h00;
          next_sp_state = spc_sp_instr;
        end
        spc_sp_instr: begin
          if (sclk_rise) begin
            next_rx = rx_sh;
            next_bit_cnt = bit_cnt + 5'h01;
            if (bit_cnt == `SPC_INSTR_LAST) begin
              next_is_read = rx_sh[15];
              next_addr = rx_sh[14:0];
              next_bit_cnt = 5'h00;
              next_load_tx = rx_sh[15];
              next_sp_state = spc_sp_data;
            end
          end
        end
        spc_sp_data: begin
          if (sclk_rise) begin
            next_rx = rx_sh;
            next_bit_cnt = bit_cnt + 5'h01;
            if (bit_cnt == `SPC_BYTE_LAST) begin
              next_bit_cnt = 5'h00;
              next_wr_pulse = ~is_read;
              next_wr_addr = addr;
              next_wr_data = frame_lsb ? rx_sh[15:8] : rx_sh[7:0];
              next_addr = frame_lsb ? addr + 15'h0001 : addr - 15'h0001;
              next_load_tx = is_read;
            end
          end else if (sclk_fall && is_read) begin
            next_sdio_out = frame_lsb ? tx[0] : tx[7];
            next_tx = frame_lsb ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
          end
        end
        default: next_sp_state = spc_sp_idle;
      endcase
    end
    next_sdio_oe_b = ~(!pin_sync.cs_b && next_sp_state == spc_sp_data && next_is_read);
  end

  // Serial engine storage
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sp_state <= spc_sp_idle;
      bit_cnt <= 5'h00;
      rx <= 16'h0000;
      frame_lsb <= 1'b0;
      is_read <= 1'b0;
      addr <= `SPC_RST_ADDR;
      load_tx <= 1'b0;
      tx <= `SPC_RST_BYTE;
      sdio_out <= 1'b0;
      sdio_oe_b <= 1'b1;
      wr_pulse <= 1'b0;
      wr_addr <= `SPC_RST_ADDR;
      wr_data <= `SPC_RST_BYTE;
    end else begin
      sp_state <= next_sp_state;
      bit_cnt <= next_bit_cnt;
      rx <= next_rx;
      frame_lsb <= next_frame_lsb;
      is_read <= next_is_read;
      addr <= next_addr;
      load_tx <= next_load_tx;
      tx <= next_tx;
      sdio_out <= next_sdio_out;
      sdio_oe_b <= next_sdio_oe_b;
      wr_pulse <= next_wr_pulse;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
    end
  end

endmodule : spc_regs

// *** rtl/spc_defines.svh ***
// Register offsets, field positions, reset values and counts of the serial control block
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// ==========================================================
// Register offsets (15-bit serial address space)
`define SPC_ADR_SER_CFG 15'h0000
`define SPC_ADR_PORT_CTL 15'h0004
`define SPC_ADR_UPDATE 15'h0005
`define SPC_ADR_ID3 15'h000a
`define SPC_ADR_ID2 15'h000b
`define SPC_ADR_ID1 15'h000c
`define SPC_ADR_ID0 15'h000d
`define SPC_ADR_PROFILE 15'h000e
`define SPC_ADR_USER_BASE 15'h0010
`define SPC_ADR_USER_LAST 15'h0017

// ==========================================================
// Field positions
`define SPC_BIT_LSB_FIRST 6
`define SPC_BIT_SOFT_RST 5
`define SPC_BIT_HW_RST 4
`define SPC_BIT_DRIVE_LOW 1
`define SPC_BIT_READ_BUF 0
`define SPC_BIT_UPDATE 0

// ==========================================================
// Reset values
`define SPC_RST_BYTE 8'h00
`define SPC_RST_PROFILE 6'h00
`define SPC_RST_ADDR 15'h0000

// ==========================================================
// Counts
`define SPC_USER_REGS 8
`define SPC_LOAD_LAST 4'h8
`define SPC_INSTR_LAST 5'h0f
`define SPC_BYTE_LAST 5'h07

`endif

// *** rtl/spc_pkg.sv ***
// Types shared by the serial control block
package spc_pkg;

  // ==========================================================
  // Serial frame states
  typedef enum logic [2:0] {
    spc_sp_idle = 3'b001,
    spc_sp_instr = 3'b010,
    spc_sp_data = 3'b100
  } spc_ser_e;

  // Profile load states
  typedef enum logic [1:0] {
    spc_ld_idle = 2'b01,
    spc_ld_run = 2'b10
  } spc_load_e;

  // Serial pins seen by the block
  typedef struct packed {
    logic sclk;
    logic cs_b;
    logic sdio_in;
  } spc_pins_s;

  // Controls handed to the device core
  typedef struct packed {
    logic core_reset;
    logic drive_reduced;
    logic update_pulse;
    logic loading;
    logic [5:0] profile;
  } spc_core_s;

endpackage : spc_pkg

// *** rtl/spc_profile_rom.sv ***
// Preset profile table: default bytes of every profile-dependent register
`timescale 1ns/10ps
`include "spc_defines.svh"

module spc_profile_rom (
  input wire logic [5:0] profile,
  input wire logic [3:0] index,
  output logic [7:0] data
);

  // ==========================================================
  // Table contents
  // Entries 0..7 are user config bytes, entry 8 holds the drive strength default
  always_comb begin
    if (index == `SPC_LOAD_LAST) begin
      data = {7'h00, profile[0]};
    end else begin
      data = (({2'b00, profile} * 8'h1d) + ({4'h0, index} * 8'h35)) ^ 8'ha5;
    end
  end

endmodule : spc_profile_rom

// *** testbench/spc_regs_props.sv ***
// Port-level checks of the serial control block
`timescale 1ns/10ps
module spc_regs_props (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire spc_pkg::spc_pins_s pins,
  input wire logic [5:0] strap_pins,
  input wire logic sdio_out,
  input wire logic sdio_oe_b,
  input wire spc_pkg::spc_core_s core,
  input wire logic [63:0] user_cfg
);
  import spc_pkg::*;
  // ==========================================
  // One clock domain for every check
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // ==========================================
  // Checks
  chk_pulse_once: assert property (
    core.update_pulse |=> !core.update_pulse) else $error("update pulse longer than one cycle");
  chk_user_cause: assert property (
    $changed(user_cfg) |-> core.update_pulse || core.loading || $past(core.update_pulse) || $past(core.loading)
    || $past(core.loading, 2)) else $error("live bytes changed without update or load");
  chk_hw_hold: assert property (
    pins.cs_b [*6] |=> $stable(core.core_reset)) else $error("core reset moved outside a frame");
  chk_load_len: assert property (
    $rose(core.loading) |-> core.loading [*8] ##[1:3] !core.loading) else $error("load length wrong");
  chk_profile_load: assert property (
    $changed(core.profile) |-> ##[0:1] core.loading) else $error("profile changed without a load");
  chk_strap_load: assert property (
    $rose(rst_b) |-> ##[1:4] core.loading) else $error("no load after reset release");
  chk_oe_frame: assert property (
    $fell(sdio_oe_b) |-> !pins.cs_b) else $error("read enable outside a frame");
  chk_oe_idle: assert property (
    pins.cs_b [*6] |-> sdio_oe_b) else $error("read enable left on after frame");
endmodule : spc_regs_props

bind spc_regs spc_regs_props u_props (.clk_sys(clk_sys), .rst_b(rst_b), .pins(pins), .strap_pins(strap_pins),
  .sdio_out(sdio_out), .sdio_oe_b(sdio_oe_b), .core(core), .user_cfg(user_cfg));

// *** testbench/spc_host_model.sv ***
// Serial host model that frames reads and writes on the configuration port
`timescale 1ns/10ps
module spc_host_model #(
  parameter int HALF = 8 // System cycles per serial clock phase
) (
  input wire logic clk_sys,
  input wire logic sdio_out,
  input wire logic sdio_oe_b,
  output spc_pkg::spc_pins_s pins
);
  import spc_pkg::*;
  logic sck = 1'b0; // Serial clock, still between frames
  logic csb = 1'b1; // Chip select, idle high
  logic hd = 1'b0; // Host data level

  // Shared data line: the block wins while its enable is low
  assign pins = '{sclk: sck, cs_b: csb, sdio_in: sdio_oe_b ? hd : sdio_out};

  // Waits one serial clock phase, then steps off the edge
  task automatic ph();
    repeat (HALF) @(posedge clk_sys);
    #1;
  endtask : ph

  // Presents one bit, raises the clock and samples the wire
  task automatic bitx(input logic b, output logic s);
    hd = b;
    ph();
    sck = 1'b1;
    s = pins.sdio_in;
    ph();
    sck = 1'b0;
  endtask : bitx

  // One frame: instruction word, then n data bytes
  task automatic xfer(input logic rnw, input logic [14:0] a, input logic lsb, input int n,
    input logic [63:0] wd, output logic [63:0] q);
    logic [15:0] w;
    logic s;
    int x;
    w = {rnw, a};
    q = 64'h0;
    csb = 1'b0;
    ph();
    for (int k = 0; k < 16; k++) bitx(lsb ? w[k] : w[15-k], s);
    for (int j = 0; j < n * 8; j++) begin
      x = (j / 8) * 8 + (lsb ? j % 8 : 7 - j % 8);
      // Released line toggles while reading
      bitx(rnw ? ~hd : wd[x], s);
      q[x] = s;
    end
    ph();
    csb = 1'b1;
    hd = ~hd;
    ph();
    ph();
  endtask : xfer
endmodule : spc_host_model

// *** testbench/tb_spc_regs.sv ***
// Self-checking bench for the serial control block
`timescale 1ns/10ps
module tb_spc_regs;
  import spc_pkg::*;
  localparam logic [31:0] IDC = 32'h3c96_e10f; // Arbitrary identification value
  localparam logic [5:0] STRAP = 6'h2b; // Strap level at power-up
  logic clk_sys = 1'b0; // System clock
  logic rst_b = 1'b0; // Synchronous reset
  logic [5:0] strap_pins = STRAP; // Profile straps
  spc_pins_s pins; // Host pins
  logic sdio_out; // Read data
  logic sdio_oe_b; // Read enable
  spc_core_s core; // Core controls
  logic [63:0] user_cfg; // Live user bytes
  int num_errors = 0; // Mismatches
  int n_compared = 0; // Comparisons
  int n_upd = 0; // Update pulses seen
  logic lo = 1'b0; // Frame bit order
  logic [63:0] q; // Last read data
  logic [63:0] keep; // Saved snapshot

  // Clock and update pulse counter
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (core.update_pulse === 1'b1) n_upd++;

  spc_regs #(.ID_CODE(IDC)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .pins(pins), .strap_pins(strap_pins),
    .sdio_out(sdio_out), .sdio_oe_b(sdio_oe_b), .core(core), .user_cfg(user_cfg));
  spc_host_model host (.clk_sys(clk_sys), .sdio_out(sdio_out), .sdio_oe_b(sdio_oe_b), .pins(pins));

  // ==========================================
  // Helpers
  task automatic cmp(input string nm, input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, lo, 1, {56'h0, d}, q);
  endtask : wr

  task automatic rd(input logic [14:0] a, input logic [7:0] e, input string nm);
    host.xfer(1'b1, a, lo, 1, 64'h0, q);
    cmp(nm, q[7:0], e);
  endtask : rd

  // Profile table bytes as the preset load should leave them
  function automatic logic [63:0] uexp(input logic [5:0] p);
    for (int k = 0; k < 8; k++) uexp[8*k+:8] = ({2'h0, p} * 8'h1d + 8'(k) * 8'h35) ^ 8'ha5;
  endfunction : uexp

  task automatic conclude();
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // ==========================================
  // Scenarios
  task automatic t_start();
    cmp("profile", core.profile, STRAP);
    cmp("user", user_cfg, uexp(STRAP));
    cmp("drive", core.drive_reduced, STRAP[0]);
    rd(15'h0, 8'h00, "ser_cfg");
    rd(15'h4, {6'h0, STRAP[0], 1'b0}, "port_ctl");
    rd(15'h5, 8'h00, "update");
    rd(15'he, {2'h0, STRAP}, "profile_rd");
  endtask : t_start

  task automatic t_ident();
    wr(15'hb, 8'hff);
    host.xfer(1'b1, 15'hd, 1'b0, 4, 64'h0, q);
    cmp("ident", q[31:0], IDC);
  endtask : t_ident

  task automatic t_reserved();
    wr(15'h0, 8'h9f);
    rd(15'h0, 8'h00, "ser_cfg");
    wr(15'h8, 8'hff);
    rd(15'h8, 8'h00, "unmapped");
  endtask : t_reserved

  task automatic t_update();
    wr(15'h10, 8'h3c);
    cmp("user", user_cfg, uexp(STRAP));
    rd(15'h10, 8'(uexp(STRAP)), "live");
    wr(15'h4, 8'h01);
    cmp("drive", core.drive_reduced, 1'b0);
    rd(15'h10, 8'h3c, "buffered");
    n_upd = 0;
    wr(15'h5, 8'h01);
    cmp("pulses", n_upd, 1);
    cmp("user0", user_cfg[7:0], 8'h3c);
    rd(15'h5, 8'h00, "update");
    wr(15'h4, 8'h00);
  endtask : t_update

  task automatic t_order();
    host.xfer(1'b0, 15'h14, 1'b0, 2, 64'h2211, q);
    wr(15'h0, 8'h40);
    lo = 1'b1;
    host.xfer(1'b0, 15'h11, 1'b1, 2, 64'hb2b1, q);
    wr(15'h5, 8'h01);
    cmp("msb_down", user_cfg[39:24], 16'h1122);
    cmp("lsb_up", user_cfg[23:8], 16'hb2b1);
    rd(15'h0, 8'h40, "ser_cfg");
    host.xfer(1'b1, 15'ha, 1'b1, 4, 64'h0, q);
    cmp("ident_lsb", q[31:0], {IDC[7:0], IDC[15:8], IDC[23:16], IDC[31:24]});
    wr(15'h0, 8'h00);
    lo = 1'b0;
  endtask : t_order

  task automatic t_hwrst();
    keep = user_cfg;
    wr(15'h4, 8'h10);
    repeat (50) @(posedge clk_sys);
    #1;
    cmp("core_reset", core.core_reset, 1'b1);
    cmp("user", user_cfg, keep);
    rd(15'h4, 8'h10, "port_ctl");
    wr(15'h4, 8'h00);
    cmp("core_reset", core.core_reset, 1'b0);
  endtask : t_hwrst

  task automatic t_soft();
    wr(15'h0, 8'h20);
    cmp("user", user_cfg, uexp(STRAP));
    rd(15'h0, 8'h00, "ser_cfg");
    rd(15'h4, {6'h0, STRAP[0], 1'b0}, "port_ctl");
  endtask : t_soft

  task automatic t_profile();
    logic [7:0] d;
    for (int i = 0; i < 2; i++) begin
      d = i ? 8'h3f : 8'hc6;
      wr(15'he, d);
      cmp("profile", core.profile, d[5:0]);
      cmp("user", user_cfg, uexp(d[5:0]));
      cmp("drive", core.drive_reduced, d[0]);
      rd(15'he, {2'h0, d[5:0]}, "profile_rd");
    end
  endtask : t_profile

  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    t_start();
    t_ident();
    t_reserved();
    t_update();
    t_order();
    t_hwrst();
    t_soft();
    t_profile();
    conclude();
  end

  // Watchdog for a hung run
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end
endmodule : tb_spc_regs
